/* File: logic/sac_top.sv */
// Conversion control and host output port of a 16-bit SAR converter.
// Assumes all inputs synchronous to clk_i; comparator_i is the SAR
// comparator decision for the trial code on dac_code_o.
`timescale 1ns/10ps
module sac_top
    import sac_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Conversion control
    input wire logic convert_start_n_i,
    input wire logic power_down_input_i,
    input wire logic [1:0] mode_i,
    output logic busy_o,
    // Analog core interface
    input wire logic comparator_i,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic track_o,
    output logic low_power_o,
    output logic core_off_o,
    // Reference and buffer power
    input wire logic internal_vsrc_off_i,
    input wire logic buffer_off_i,
    output logic vsrc_enable_o,
    output logic buffer_enable_o,
    output logic buffer_gain2_o,
    // Output coding and port select
    input wire logic coding_select_i,
    input wire logic serial_parallel_select_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    // Shared data pins (serial on bit 15, clock on bit 14)
    output logic [RES_BITS-1:0] data_o,
    output logic [RES_BITS-1:0] data_oe_o,
    output logic result_lost_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sac_state_t state_reg;             // Sequencer state
    logic start_n_prev_reg;            // Previous start level
    logic [RES_BITS-1:0] trial_reg;    // Successive trial code
    logic [RES_BITS-1:0] bit_reg;      // One-hot bit under test
    logic [RES_BITS-1:0] result_reg;   // Coded result awaiting store
    logic [DIV_W-1:0] acq_cnt_reg;     // Self-timed acquisition count
    logic [1:0] mode_reg;              // Mode captured at start
    logic [DIV_W-1:0] bit_load;        // Bit time for current mode
    logic bit_tick;                    // One bit decision per tick
    logic start_fall;                  // Start edge seen
    logic start_req;                   // Start accepted this cycle
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RES_BITS-1:0] fifo_out_data;
    logic fifo_pop;
    logic port_en;                     // Select and read both low
    logic port_en_prev_reg;            // For end-of-read detection
    logic ser_active_reg;              // Serial word in flight
    logic [RES_BITS-1:0] shift_reg;    // Serial shifter
    logic [4:0] shift_cnt_reg;         // Bits still to send
    logic sclk_reg;                    // Serial clock level
    logic sclk_tick;                   // Serial half-period tick
    logic [RES_BITS-1:0] coded;        // Result in chosen coding

    // ------------------------------------------------------------
    // Start detection
    // ------------------------------------------------------------
    // Edge detect on start; select and read play no part
    assign start_fall = start_n_prev_reg && !convert_start_n_i;
    // Power-down blocks new starts from idle and restarts from WAIT
    assign start_req = start_fall && !power_down_input_i;

    // Previous start level; reset high so a held-low start after
    // power-up counts as the first request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_n_prev_reg <= 1'b1;
        end else begin
            start_n_prev_reg <= convert_start_n_i;
        end
    end

    // Bit time of the running mode, or of the mode about to be latched,
    // so the first bit of a conversion is not timed by the last mode
    always_comb begin
        case ((state_reg == SAC_CONV) ? mode_reg : mode_i)
            MODE_WARP: bit_load = DIV_W'(BIT_CYC_WARP);
            MODE_IMPULSE: bit_load = DIV_W'(BIT_CYC_IMP);
            default: bit_load = DIV_W'(BIT_CYC_NORM);
        endcase
    end

    // Bit decision pacing, runs only while converting
    sac_tick_div u_bit_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(state_reg == SAC_CONV),
        .load_i(bit_load),
        .tick_o(bit_tick)
    );

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // Only IDLE and WAIT look at start requests; CONV ignores both
    // start and power-down until the last bit is decided
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= SAC_IDLE;
            mode_reg <= MODE_NORMAL;
            acq_cnt_reg <= '0;
        end else begin
            case (state_reg)
                SAC_IDLE: begin
                    // Normal and warp: one edge, one conversion; impulse repeats while start is held low
                    if (start_req) begin
                        state_reg <= SAC_CONV;
                        mode_reg <= mode_i;
                    end
                end
                SAC_CONV: begin
                    // Runs to the last bit regardless of inputs
                    if (bit_tick && bit_reg[0]) begin
                        state_reg <= SAC_STORE;
                    end
                end
                SAC_STORE: begin
                    // Waits here if the FIFO is full
                    if (fifo_in_ready) begin
                        if (mode_reg == MODE_IMPULSE) begin
                            state_reg <= SAC_ACQ;
                            acq_cnt_reg <= DIV_W'(ACQ_CYC);
                        end else begin
                            state_reg <= SAC_IDLE;
                        end
                    end
                end
                SAC_ACQ: begin
                    // Self-timed acquisition; rate may beat the
                    // nominal low-power limit slightly
                    if (acq_cnt_reg > DIV_W'(1)) begin
                        acq_cnt_reg <= acq_cnt_reg - DIV_W'(1);
                    end else begin
                        state_reg <= SAC_WAIT;
                    end
                end
                SAC_WAIT: begin
                    // Held low: restart; released: back to idle
                    if (!convert_start_n_i && !power_down_input_i) begin
                        state_reg <= SAC_CONV;
                        mode_reg <= mode_i;
                    end else begin
                        state_reg <= SAC_IDLE;
                    end
                end
                default: begin
                    state_reg <= SAC_IDLE;
                end
            endcase
        end
    end

    // Successive approximation: MSB first, keep or drop each trial
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trial_reg <= '0;
            bit_reg <= '0;
        end else if (state_reg != SAC_CONV) begin
            trial_reg <= TRIAL_MSB;
            bit_reg <= TRIAL_MSB;
        end else if (bit_tick) begin
            trial_reg <= (comparator_i ? trial_reg : trial_reg & ~bit_reg)
                | (bit_reg >> 1);
            bit_reg <= bit_reg >> 1;
        end
    end

    // Two's complement differs from offset binary only in the MSB
    assign coded = {trial_reg[RES_BITS-1] ^ coding_select_i,
        trial_reg[RES_BITS-2:0]};

    // Final code captured on the last decision
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_reg <= RESULT_RST;
        end else if (state_reg == SAC_CONV && bit_tick && bit_reg[0]) begin
            result_reg <= {coded[RES_BITS-1:1], comparator_i};
        end
    end

    // ------------------------------------------------------------
    // Status and analog control outputs
    // ------------------------------------------------------------
    // Busy rises the cycle after a start is taken; falls on store
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else if (state_reg == SAC_IDLE) begin
            busy_o <= start_req;
        end else if (state_reg == SAC_WAIT) begin
            busy_o <= !convert_start_n_i && !power_down_input_i;
        end else if (state_reg == SAC_STORE) begin
            busy_o <= !fifo_in_ready;
        end
    end

    // Analog core steering; digital port is never powered down
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dac_code_o <= '0;
            track_o <= 1'b1;
            low_power_o <= 1'b0;
            core_off_o <= 1'b0;
        end else begin
            dac_code_o <= trial_reg;
            track_o <= (state_reg != SAC_CONV);
            // Reduced power outside conversion in low-power mode
            low_power_o <= (mode_reg == MODE_IMPULSE)
                && (state_reg != SAC_CONV);
            // Power-down never cuts a conversion short
            core_off_o <= power_down_input_i
                && (state_reg == SAC_IDLE);
        end
    end

    // Reference and buffer follow only their own pins
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vsrc_enable_o <= 1'b0;
            buffer_enable_o <= 1'b0;
            buffer_gain2_o <= 1'b0;
        end else begin
            vsrc_enable_o <= !internal_vsrc_off_i;
            buffer_enable_o <= !buffer_off_i;
            // Gain 2 only with internal source feeding the buffer
            buffer_gain2_o <= !internal_vsrc_off_i
                && !buffer_off_i;
            // External at buffer input gives gain 1 above
            // both high leaves both disabled above
        end
    end

    // ------------------------------------------------------------
    // Result buffering
    // ------------------------------------------------------------
    assign fifo_in_valid = (state_reg == SAC_STORE);

    // Full FIFO holds the sequencer in STORE with busy high
    sac_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_in_valid),
        .in_data_i(result_reg),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_pop)
    );

    // Flag a result that had to wait for room
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_lost_o <= 1'b0;
        end else begin
            result_lost_o <= fifo_in_valid && !fifo_in_ready;
        end
    end

    // ------------------------------------------------------------
    // Host output port
    // ------------------------------------------------------------
    // Select and read are ORed: either high disables the port
    assign port_en = !(cs_n_i || rd_n_i);

    // Parallel read pops at the end of the read strobe; serial
    // pops after the last bit leaves the shifter
    assign fifo_pop = fifo_out_valid && (serial_parallel_select_i
        ? (ser_active_reg && shift_cnt_reg == 5'h01 && sclk_tick
            && sclk_reg)
        : (port_en_prev_reg && !port_en));

    // Serial clock from the divider while a word is in flight
    sac_tick_div u_sclk_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(ser_active_reg && port_en),
        .load_i(DIV_W'(SCLK_HALF_CYC)),
        .tick_o(sclk_tick)
    );

    // Serial shifter, MSB first; data changes on the falling edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_en_prev_reg <= 1'b0;
            ser_active_reg <= 1'b0;
            shift_reg <= '0;
            shift_cnt_reg <= '0;
            sclk_reg <= 1'b0;
        end else begin
            port_en_prev_reg <= port_en;
            if (!port_en || !serial_parallel_select_i) begin
                ser_active_reg <= 1'b0;
                sclk_reg <= 1'b0;
            end else if (!ser_active_reg && fifo_out_valid
                && !fifo_pop) begin
                ser_active_reg <= 1'b1;
                shift_reg <= fifo_out_data;
                shift_cnt_reg <= 5'h10;
            end else if (ser_active_reg && sclk_tick) begin
                sclk_reg <= !sclk_reg;
                if (sclk_reg) begin
                    shift_reg <= shift_reg << 1;
                    shift_cnt_reg <= shift_cnt_reg - 5'h01;
                    if (shift_cnt_reg == 5'h01) begin
                        ser_active_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // Shared pins: parallel word or serial data and clock
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_o <= '0;
            data_oe_o <= '0;
        end else if (!port_en) begin
            data_o <= '0;
            data_oe_o <= '0;
        end else if (serial_parallel_select_i) begin
            // Only two pins of the bus carry the serial link
            data_o <= {shift_reg[RES_BITS-1], sclk_reg,
                {(RES_BITS-2){1'b0}}};
            data_oe_o <= {2'b11, {(RES_BITS-2){1'b0}}};
        end else begin
            data_o <= fifo_out_data;
            data_oe_o <= '1;
        end
    end

endmodule

/* File: logic/sac_pkg.sv */
// Shared constants for the sampling converter control and host port.
// Assumes a single 250 MHz clock; all conversion timing is counted
// internally from it.
package sac_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;      // 250 MHz system clock
    localparam int BIT_TIME_WARP_NS = 40;  // One bit decision, fastest
    localparam int BIT_TIME_NORM_NS = 50;  // One bit decision, normal
    localparam int BIT_TIME_IMP_NS = 60;   // One bit decision, low power
    localparam int ACQ_TIME_NS = 280;      // Self-timed acquisition
    localparam int SCLK_HALF_NS = 20;      // Serial clock half period

    // Least times round up to whole cycles, never below one
    localparam int BIT_CYC_WARP =
        (BIT_TIME_WARP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYC_NORM =
        (BIT_TIME_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYC_IMP =
        (BIT_TIME_IMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_CYC =
        (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Sizes, encodings and reset values
    // ------------------------------------------------------------
    localparam int RES_BITS = 16;          // Result width
    localparam int DIV_W = 8;              // Divider load width
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_WARP = 2'h1;
    localparam logic [1:0] MODE_IMPULSE = 2'h2;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] TRIAL_MSB = 16'h8000;

    // Conversion sequencer states, one-hot
    typedef enum logic [4:0] {
        SAC_IDLE  = 5'b0_0001,
        SAC_CONV  = 5'b0_0010,
        SAC_STORE = 5'b0_0100,
        SAC_ACQ   = 5'b0_1000,
        SAC_WAIT  = 5'b1_0000
    } sac_state_t;

endpackage

/* File: logic/sac_tick_div.sv */
// Enable divider: one-cycle tick every load_i cycles while en_i.
// Assumes load_i is at least one and held steady while running.
`timescale 1ns/10ps
module sac_tick_div
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic en_i,
    input wire logic [DIV_W-1:0] load_i,
    // Output
    output logic tick_o
);

    logic [DIV_W-1:0] cnt_reg; // Cycles left to next tick

    // Count down, reload on tick; restart whenever disabled
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (!en_i) begin
            cnt_reg <= load_i - DIV_W'(1);
            tick_o <= 1'b0;
        end else if (cnt_reg == '0) begin
            cnt_reg <= load_i - DIV_W'(1);
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg - DIV_W'(1);
            tick_o <= 1'b0;
        end
    end

endmodule

/* File: logic/sac_fifo.sv */
// Result FIFO: first-word-fall-through, read data from a register.
// Assumes DEPTH is a power of two.
`timescale 1ns/10ps
module sac_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage
    logic [AW-1:0] wptr_reg;         // Write pointer
    logic [AW-1:0] rptr_reg;         // Read pointer
    logic [AW:0] count_reg;          // Words held
    logic push;
    logic pop;
    logic [AW-1:0] rptr_next;

    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign rptr_next = pop ? rptr_reg + AW'(1) : rptr_reg;

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr_reg] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + AW'(1);
            end
            rptr_reg <= rptr_next;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Head word register, bypass when writing the next head
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_data_o <= '0;
        end else if (push && wptr_reg == rptr_next) begin
            out_data_o <= in_data_i;
        end else begin
            out_data_o <= mem[rptr_next];
        end
    end

endmodule

/* File: bench/sac_checker.sv */
// Port checker for sac_top, bound to every instance of it.
// Assumes the host keeps cs_n_i high through reset.
`timescale 1ns/10ps
module sac_checker
    import sac_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic convert_start_n_i,
    input wire logic internal_vsrc_off_i,
    input wire logic buffer_off_i,
    input wire logic serial_parallel_select_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    // Outputs watched
    input wire logic busy_o,
    input wire logic track_o,
    input wire logic low_power_o,
    input wire logic core_off_o,
    input wire logic vsrc_enable_o,
    input wire logic buffer_enable_o,
    input wire logic buffer_gain2_o,
    input wire logic [RES_BITS-1:0] data_oe_o
);
    // ----------------------------------------
    // One domain, so one clock and disable
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_busy_cause: assert property ($rose(busy_o) |->
        !$past(convert_start_n_i)) else $error("busy rose without start");
    chk_busy_hold: assert property ($rose(busy_o) |->
        busy_o [*8]) else $error("busy too short");
    chk_track_drop: assert property ($rose(busy_o) |=>
        !track_o) else $error("track still high in conversion");
    chk_power_wake: assert property ($rose(busy_o) |=>
        !low_power_o) else $error("low power during conversion");
    chk_port_float: assert property ((cs_n_i || rd_n_i) |=>
        data_oe_o == '0) else $error("pins driven while deselected");
    chk_par_drive: assert property ((!cs_n_i && !rd_n_i &&
        !serial_parallel_select_i) |=> &data_oe_o)
        else $error("parallel bus not driven");
    chk_ser_pins: assert property (serial_parallel_select_i |=>
        data_oe_o[13:0] == '0) else $error("serial drives bus pins");
    chk_ref_map: assert property (!$past(sys_rst_i) |->
        vsrc_enable_o == !$past(internal_vsrc_off_i) &&
        buffer_enable_o == !$past(buffer_off_i)) else $error("ref map");
    chk_gain_map: assert property (!$past(sys_rst_i) |->
        buffer_gain2_o == !$past(internal_vsrc_off_i | buffer_off_i))
        else $error("buffer gain wrong");
    chk_core_awake: assert property (busy_o |->
        !core_off_o) else $error("core off during conversion");
endmodule

bind sac_top sac_checker i_sac_checker (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .convert_start_n_i(convert_start_n_i),
    .internal_vsrc_off_i(internal_vsrc_off_i), .buffer_off_i(buffer_off_i),
    .serial_parallel_select_i(serial_parallel_select_i), .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i), .busy_o(busy_o), .track_o(track_o),
    .low_power_o(low_power_o), .core_off_o(core_off_o),
    .vsrc_enable_o(vsrc_enable_o),
    .buffer_enable_o(buffer_enable_o), .buffer_gain2_o(buffer_gain2_o),
    .data_oe_o(data_oe_o));

/* File: bench/sac_core_model.sv */
// Behavioural analog core: compares each trial code with a held sample.
// Assumes the bench changes the sample only while busy is low.
`timescale 1ns/10ps
module sac_core_model
    import sac_pkg::*;
(
    // Held sample and trial code
    input wire logic [RES_BITS-1:0] sample_i,
    input wire logic [RES_BITS-1:0] dac_code_i,
    // Decision back to the sequencer
    output logic comparator_o
);
    // Keep a trial bit only while it does not overshoot the sample
    assign comparator_o = (dac_code_i <= sample_i);
endmodule

/* File: bench/sac_top_test.sv */
// Self-checking bench for sac_top with the behavioural core model.
// Assumes the one 250 MHz clock; inputs change on the falling edge.
`timescale 1ns/10ps
module sac_top_test;
    import sac_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, start_n = 1, pd = 0, cmp, busy, track;
    logic vsrc_off = 0, buf_off = 0, coding = 0, ser = 0, cs_n = 1, rd_n = 1;
    logic ven, ben, g2, lost;
    logic [1:0] mode = MODE_NORMAL;
    logic [15:0] dac, data, oe, smp = 16'h0000;
    int mismatches = 0, n_compared = 0, cyc = 0;
    always #2 clk_i = ~clk_i;
    sac_top #(.FIFO_DEPTH(16)) i_sac_top (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .convert_start_n_i(start_n),
        .power_down_input_i(pd), .mode_i(mode), .busy_o(busy),
        .comparator_i(cmp), .dac_code_o(dac), .track_o(track),
        .low_power_o(), .core_off_o(), .internal_vsrc_off_i(vsrc_off),
        .buffer_off_i(buf_off), .vsrc_enable_o(ven), .buffer_enable_o(ben),
        .buffer_gain2_o(g2), .coding_select_i(coding),
        .serial_parallel_select_i(ser), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .data_o(data), .data_oe_o(oe), .result_lost_o(lost));
    sac_core_model i_sac_core_model (.sample_i(smp), .dac_code_i(dac),
        .comparator_o(cmp));
    // ----------------------------------------
    // Compare, verdict and hang guard
    // ----------------------------------------
    task automatic cmp_word(string what, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Whole run is near 7000 cycles, so this leaves ample margin
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict;
        end
    end
    // ----------------------------------------
    // Host access tasks
    // ----------------------------------------
    function automatic logic [15:0] code(logic [15:0] s);
        return coding ? s ^ TRIAL_MSB : s;
    endfunction
    task automatic wait_busy(logic v, int lim);
        for (int k = 0; k < lim && busy !== v; k++) @(negedge clk_i);
        cmp_word("busy", {15'h0, v}, {15'h0, busy});
    endtask
    // One conversion, two for impulse with hold; a stray start in mid-conversion must be ignored
    task automatic run(logic [1:0] m, logic [15:0] s, logic hold, logic p);
        @(negedge clk_i);
        mode = m;
        smp = s;
        start_n = 0;
        wait_busy(1, 4);
        start_n = !hold;
        pd = p;
        repeat (3) @(negedge clk_i);
        start_n = 0;
        @(negedge clk_i);
        start_n = !hold;
        wait_busy(0, 400);
        pd = 0;
        for (int k = 0; k < ACQ_CYC + 10 && !busy; k++) @(negedge clk_i);
        cmp_word("restart", {15'h0, hold && m == MODE_IMPULSE},
            {15'h0, busy});
        start_n = 1;
        wait_busy(0, 400);
        // Starts during acquisition are ignored; let a self-run wind down
        if (m == MODE_IMPULSE) repeat (ACQ_CYC + 4) @(negedge clk_i);
    endtask
    task automatic read_par(logic [15:0] e);
        @(negedge clk_i);
        cs_n = 0;
        rd_n = 0;
        repeat (2) @(negedge clk_i);
        cmp_word("parallel", e, data);
        cs_n = 1;
        rd_n = 1;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic read_ser(logic [15:0] e);
        logic [15:0] w;
        logic prev;
        w = 16'h0000;
        prev = 0;
        ser = 1;
        cs_n = 0;
        rd_n = 0;
        for (int n = 0, k = 0; n < 16 && k < 400; k++) begin
            @(negedge clk_i);
            if (data[14] && !prev) begin
                w = {w[14:0], data[15]};
                n++;
            end
            prev = data[14];
        end
        // Stay selected until the last clock fall pops the word
        repeat (8) @(negedge clk_i);
        cmp_word("serial", e, w);
        cs_n = 1;
        rd_n = 1;
        repeat (3) @(negedge clk_i);
        ser = 0;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 0;
        cmp_word("track", 16'h0001, {15'h0, track});
        for (int i = 0; i < 8; i++) begin
            {pd, vsrc_off, buf_off} = i[2:0];
            repeat (2) @(negedge clk_i);
            cmp_word("refs", {14'h0, !vsrc_off, !buf_off},
                {14'h0, ven, ben});
            cmp_word("gain", {15'h0, !vsrc_off && !buf_off},
                {15'h0, g2});
        end
        start_n = 0;
        repeat (10) @(negedge clk_i);
        cmp_word("busy", 16'h0000, {15'h0, busy});
        start_n = 1;
        @(negedge clk_i);
        {pd, vsrc_off, buf_off} = 3'h0;
        for (int i = 1; i < 4; i++) begin
            {cs_n, rd_n} = i[1:0];
            run(MODE_WARP, 16'h0100 * i[15:0], 0, 0);
            cmp_word("enables", 16'h0000, oe);
        end
        for (int i = 1; i < 4; i++) read_par(16'h0100 * i[15:0]);
        for (int m = 0; m < 3; m++) begin
            coding = m[0];
            run(m[1:0], 16'hA5C3 + m[15:0], 1, m == 1);
            read_par(code(16'hA5C3 + m[15:0]));
            if (m == MODE_IMPULSE) read_par(code(16'hA5C3 + m[15:0]));
        end
        coding = 0;
        run(MODE_NORMAL, 16'h3C96, 0, 0);
        read_ser(16'h3C96);
        for (int i = 0; i < 16; i++) run(MODE_WARP, 16'h1111 * i[15:0], 0, 0);
        start_n = 0;
        repeat (300) @(negedge clk_i);
        cmp_word("stall", 16'h0003, {14'h0, busy, lost});
        start_n = 1;
        for (int i = 0; i < 16; i++) read_par(16'h1111 * i[15:0]);
        // Stalled conversion took the last sample set
        read_par(16'hFFFF);
        wait_busy(0, 20);
        give_verdict;
    end
endmodule
